// file: hw/dmm_pkg.sv
/*
 * Shared constants and carrier types for the multiply datapath.
 * Assumes one core clock and a classic Wishbone master for its registers.
 */
package dmm_pkg;

    // ***************************************************************
    // Widths
    // ***************************************************************
    localparam int ACC_W = 40;
    localparam int WORD_W = 16;
    localparam int OPND_W = 17;
    localparam int PROD_W = 34;
    localparam int RES_W = 32;
    localparam int IMM_W = 8;
    localparam int SLICE_HI = 32;
    localparam int SLICE_LO = 16;
    localparam int N_ACC = 4;

    // ***************************************************************
    // Register map (byte offsets) and reset values
    // ***************************************************************
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [6:0] MODE_RST = 7'h20;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [31:0] COUNT_RST = 32'h0000_0000;

    // ***************************************************************
    // Arithmetic constants
    // ***************************************************************
    localparam logic [40:0] RND_HALF = 41'h000_0000_8000;
    localparam logic [15:0] RND_TIE = 16'h8000;
    localparam logic [16:0] OPND_MIN = 17'h1_8000;
    localparam logic [31:0] MUL_SAT = 32'h7fff_ffff;
    localparam logic [39:0] SAT40_POS = 40'h7f_ffff_ffff;
    localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;
    localparam logic [39:0] SAT32_POS = 40'h00_7fff_ffff;
    localparam logic [39:0] SAT32_NEG = 40'hff_8000_0000;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef enum logic [5:0] {
        FORM_ACC_ACC = 6'h01,
        FORM_ACC_T   = 6'h02,
        FORM_ACC_K8  = 6'h04,
        FORM_MEM_ACC = 6'h08,
        FORM_MEM_K8  = 6'h10,
        FORM_MEM_MEM = 6'h20
    } dmm_form_t;

    // Bit 6 is the top field; reset sets sign extension mode only.
    typedef struct packed {
        logic legacy_compat_mode_bit;
        logic sign_extension_mode_bit;
        logic saturate_on_multiply_bit;
        logic data_saturation_bit;
        logic rounding_method_bit;
        logic wide_overflow_mode_bit;
        logic fractional_mode_bit;
    } dmm_mode_t;

    typedef struct packed {
        logic valid;
        dmm_form_t form;
        logic rnd;
        logic uns_x;
        logic uns_y;
        logic copy_t3;
        logic [1:0] dst_idx;
        logic [39:0] source_accumulator;
        logic [39:0] dest_accumulator;
        logic [15:0] temp;
        logic [15:0] mem_x;
        logic [15:0] mem_y;
        logic [7:0] short_immediate_constant;
    } dmm_op_t;

    typedef struct packed {
        logic [39:0] acc;
        logic ovf;
        logic [1:0] dst_idx;
    } dmm_res_t;

endpackage

// file: hw/dmm_mul_top.sv
/*
 * Single-cycle multiply datapath of the data-unit multiply-accumulate.
 * Assumes the decoder presents one operation per cycle on op_i from logic
 * on clk_i, and a classic Wishbone master reaches the mode and status
 * registers.
 */
// Functional notes
// - Accumulator by accumulator multiplies bits 32..16 of both.
// - Accumulator by temp: accumulator slice times sign-extended temp.
// - Fractional mode shifts the raw product left by one bit.
// - Saturate-on-multiply saturates fractional min times min inside multiplier.
// - The 32-bit product is sign-extended to 40 bits.
// - Round by rounding method only when the rounding qualifier is set.
// - Overflow at 32 or 40 bits by wide mode sets dest flag.
// - On overflow saturate if data saturation set, else wrap.
// - Legacy mode gives identical results when wide mode is clear.
// - Every multiply form completes in one cycle.
// - Six mode bits steer it; only dest overflow flag changes.
// - Copy qualifier writes the memory operand into temp register three.
// - Short constant is sign-extended to 17 bits.
// - Unsigned memory operand zero-extends, else extends per sign mode.
`timescale 1ns/1ns
module dmm_mul_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire dmm_pkg::dmm_op_t op_i,
    output logic res_valid_o,
    output dmm_pkg::dmm_res_t res_o,
    output logic t3_we_o,
    output logic [15:0] t3_data_o,
    output logic [3:0] ovf_flags_o,
    output dmm_pkg::dmm_mode_t mode_o
);

    // ***************************************************************
    // Register bus
    // ***************************************************************
    dmm_pkg::dmm_mode_t mode;
    logic [3:0] ovf_flag;
    logic [31:0] op_count;
    logic bus_req;
    logic bus_wr;
    logic [31:0] next_rdata;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

    // Unmapped offsets are acknowledged, read as zero and ignore writes.
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            dmm_pkg::OFS_MODE: next_rdata = {25'h0, mode};
            dmm_pkg::OFS_STATUS: next_rdata = {28'h0, ovf_flag};
            dmm_pkg::OFS_COUNT: next_rdata = op_count;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? next_rdata : 32'h0000_0000;
        end
    end

    // The legacy bit is only held: the datapath is already legacy-exact
    // while wide overflow mode is clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= dmm_pkg::MODE_RST;
        end else if (ce_i && bus_wr && wb_adr_i == dmm_pkg::OFS_MODE) begin
            mode <= wb_dat_i[6:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_o <= dmm_pkg::MODE_RST;
        end else if (ce_i) begin
            mode_o <= (bus_wr && wb_adr_i == dmm_pkg::OFS_MODE)
                ? wb_dat_i[6:0] : mode;
        end
    end

    // ***************************************************************
    // Operand selection
    // ***************************************************************
    logic issue;
    logic [16:0] acc_src_hi;
    logic [16:0] acc_dst_hi;
    logic [16:0] ext_mem_x;
    logic [16:0] ext_mem_y;
    logic [16:0] ext_temp;
    logic [16:0] ext_imm;
    logic [16:0] opnd_a;
    logic [16:0] opnd_b;
    logic uses_mem;

    assign issue = ce_i && op_i.valid;

    // Upper accumulator slices.
    assign acc_src_hi = op_i.source_accumulator[dmm_pkg::SLICE_HI:
                                                dmm_pkg::SLICE_LO];
    assign acc_dst_hi = op_i.dest_accumulator[dmm_pkg::SLICE_HI:
                                              dmm_pkg::SLICE_LO];

    // Temp register is always sign-extended.
    assign ext_temp = {op_i.temp[15], op_i.temp};
    // Short constant sign-extended to 17 bits.
    assign ext_imm = {{9{op_i.short_immediate_constant[7]}},
                      op_i.short_immediate_constant};
    // Memory operands: zero for unsigned, else per sign mode.
    assign ext_mem_x = {!op_i.uns_x && mode.sign_extension_mode_bit
                        && op_i.mem_x[15], op_i.mem_x};
    assign ext_mem_y = {!op_i.uns_y && mode.sign_extension_mode_bit
                        && op_i.mem_y[15], op_i.mem_y};

    always_comb begin
        opnd_a = acc_src_hi;
        opnd_b = acc_dst_hi;
        uses_mem = 1'b0;
        case (op_i.form)
            dmm_pkg::FORM_ACC_ACC: begin
                opnd_a = acc_src_hi;
                opnd_b = acc_dst_hi;
            end
            dmm_pkg::FORM_ACC_T: begin
                opnd_a = acc_src_hi;
                opnd_b = ext_temp;
            end
            dmm_pkg::FORM_ACC_K8: begin
                opnd_a = acc_src_hi;
                opnd_b = ext_imm;
            end
            dmm_pkg::FORM_MEM_ACC: begin
                opnd_a = ext_mem_x;
                opnd_b = acc_src_hi;
                uses_mem = 1'b1;
            end
            dmm_pkg::FORM_MEM_K8: begin
                opnd_a = ext_mem_x;
                opnd_b = ext_imm;
                uses_mem = 1'b1;
            end
            dmm_pkg::FORM_MEM_MEM: begin
                opnd_a = ext_mem_x;
                opnd_b = ext_mem_y;
                uses_mem = 1'b1;
            end
            default: begin
                opnd_a = acc_src_hi;
                opnd_b = acc_dst_hi;
                uses_mem = 1'b0;
            end
        endcase
    end

    // ***************************************************************
    // Multiplier and result shaping
    // ***************************************************************
    logic signed [33:0] prod_raw;
    logic [33:0] prod_shift;
    logic [31:0] prod32;
    logic [39:0] prod40;
    logic [40:0] rnd_inc;
    logic [40:0] sum41;
    logic [40:0] rounded;
    logic ovf32;
    logic ovf40;
    logic ovf;
    logic [39:0] next_acc;

    // A 17x17 signed array covers signed and zero-extended 16-bit inputs
    // without a separate unsigned path.
    assign prod_raw = $signed(opnd_a) * $signed(opnd_b);

    // Fractional doubling before any other processing.
    assign prod_shift = mode.fractional_mode_bit
        ? {prod_raw[32:0], 1'b0} : prod_raw;

    // Min times min in fractional mode overflows 32 bits and is saturated
    // here when requested; other 32-bit overflows, from wider operands, are truncated.
    always_comb begin
        prod32 = prod_shift[31:0];
        if (mode.saturate_on_multiply_bit && mode.fractional_mode_bit &&
            opnd_a == dmm_pkg::OPND_MIN && opnd_b == dmm_pkg::OPND_MIN) begin
            prod32 = dmm_pkg::MUL_SAT;
        end
    end

    assign prod40 = {{8{prod32[31]}}, prod32};

    // Method 0 rounds half up; method 1 rounds a tie to the even neighbour.
    always_comb begin
        rnd_inc = 41'h0;
        if (op_i.rnd) begin
            rnd_inc = dmm_pkg::RND_HALF;
            if (mode.rounding_method_bit && prod40[16] == 1'b0 &&
                prod40[15:0] == dmm_pkg::RND_TIE) begin
                rnd_inc = 41'h0;
            end
        end
    end

    assign sum41 = {prod40[39], prod40} + rnd_inc;
    assign rounded = op_i.rnd ? {sum41[40:16], 16'h0000} : sum41;

    // Overflow boundary chosen by wide mode.
    assign ovf40 = rounded[40] ^ rounded[39];
    assign ovf32 = !(&rounded[40:31] || ~|rounded[40:31]);
    assign ovf = mode.wide_overflow_mode_bit ? ovf40 : ovf32;

    // Saturate toward the sign of the exact result.
    always_comb begin
        next_acc = rounded[39:0];
        if (ovf && mode.data_saturation_bit) begin
            if (mode.wide_overflow_mode_bit) begin
                next_acc = rounded[40] ? dmm_pkg::SAT40_NEG
                                       : dmm_pkg::SAT40_POS;
            end else begin
                next_acc = rounded[40] ? dmm_pkg::SAT32_NEG
                                       : dmm_pkg::SAT32_POS;
            end
        end
    end

    // ***************************************************************
    // Result, copy and status registers
    // ***************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_valid_o <= 1'b0;
            res_o <= '0;
        end else if (ce_i) begin
            res_valid_o <= op_i.valid;
            if (op_i.valid) begin
                res_o.acc <= next_acc;
                res_o.ovf <= ovf;
                res_o.dst_idx <= op_i.dst_idx;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t3_we_o <= 1'b0;
            t3_data_o <= 16'h0000;
        end else if (ce_i) begin
            t3_we_o <= op_i.valid && op_i.copy_t3 && uses_mem;
            if (op_i.valid && op_i.copy_t3 && uses_mem) begin
                t3_data_o <= op_i.mem_x;
            end
        end
    end

    // Sticky flags; a set in the same cycle as a write-one clear wins.
    // An operation only ever sets the destination's flag.
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    assign flag_set = (issue && ovf) ? (4'h1 << op_i.dst_idx) : 4'h0;
    assign flag_clr = (bus_wr && wb_adr_i == dmm_pkg::OFS_STATUS)
        ? wb_dat_i[3:0] : 4'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_flag <= dmm_pkg::STATUS_RST;
            ovf_flags_o <= dmm_pkg::STATUS_RST;
        end else if (ce_i) begin
            ovf_flag <= (ovf_flag & ~flag_clr) | flag_set;
            ovf_flags_o <= (ovf_flag & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_count <= dmm_pkg::COUNT_RST;
        end else if (issue) begin
            op_count <= op_count + 32'h0000_0001;
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_single_cycle_res: assert property (
        issue |=> res_valid_o && res_o.dst_idx == $past(op_i.dst_idx))
        else $error("Multiply result did not appear one cycle later.");

    a_fractional_mode_bit_even_lsb: assert property (
        issue && mode.fractional_mode_bit && !op_i.rnd &&
        !mode.saturate_on_multiply_bit && !mode.data_saturation_bit
        |=> res_o.acc[0] == 1'b0)
        else $error("Fractional product has an odd low bit.");

    a_mul_sat_value: assert property (
        issue && mode.saturate_on_multiply_bit &&
        mode.fractional_mode_bit && !op_i.rnd &&
        mode.wide_overflow_mode_bit &&
        opnd_a == dmm_pkg::OPND_MIN && opnd_b == dmm_pkg::OPND_MIN
        |=> res_o.acc == {8'h00, dmm_pkg::MUL_SAT})
        else $error("Product overflow was not saturated.");

    a_sext_narrow: assert property (
        issue && !op_i.rnd |=> &res_o.acc[39:31] || ~|res_o.acc[39:31])
        else $error("Product is not sign-extended to 40 bits.");

    a_rnd_low_zero: assert property (
        issue && op_i.rnd && !mode.data_saturation_bit
        |=> res_o.acc[15:0] == 16'h0000)
        else $error("Rounded result has nonzero low half.");

    a_ovf_flag_set: assert property (
        res_valid_o && res_o.ovf |-> ovf_flag[res_o.dst_idx])
        else $error("Overflow did not set the destination flag.");

    a_sat_narrow: assert property (
        issue && ovf && mode.data_saturation_bit &&
        !mode.wide_overflow_mode_bit
        |=> res_o.acc == dmm_pkg::SAT32_POS ||
            res_o.acc == dmm_pkg::SAT32_NEG)
        else $error("Overflowed result not saturated at 32 bits.");

    a_t3_copy: assert property (
        issue && op_i.copy_t3 && uses_mem
        |=> t3_we_o && t3_data_o == $past(op_i.mem_x))
        else $error("Memory operand not copied to temp register three.");

    a_uns_zero_ext: assert property (
        issue && uses_mem && op_i.uns_x
        |-> opnd_a == {1'b0, op_i.mem_x})
        else $error("Unsigned memory operand was sign-extended.");

    a_ack_one_cycle: assert property (
        wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("Bus acknowledge held longer than one cycle.");

endmodule

// file: sim/dmm_feed.sv
/*
 * Decoder and operand fetch model that feeds op_i of the multiply datapath.
 * Assumes the bench calls send and rest from one process on clk_i.
 */
`timescale 1ns/1ns
module dmm_feed (
    input wire logic clk_i,
    output dmm_pkg::dmm_op_t op_o
);
    logic [148:0] idle;

    initial begin
        op_o = '0;
        idle = '0;
    end

    // Presents one operation and holds it until the next send or rest; a
    // following send keeps the stream back to back.
    task automatic send(input dmm_pkg::dmm_op_t o);
        @(posedge clk_i);
        op_o <= o;
        idle = ~o;
    endtask

    // Idle cycles clear valid; the first repeats the last sent fields, later ones alternately flip and restore them.
    task automatic rest(input int n);
        repeat (n) begin
            @(posedge clk_i);
            idle = ~idle;
            op_o <= {1'b0, idle[147:0]};
        end
    endtask
endmodule

// file: sim/dmm_mul_top_bench.sv
/*
 * Self-checking bench for the multiply datapath.
 * Assumes dmm_feed plays the decoder and this bench is the Wishbone master.
 */
`timescale 1ns/1ns
module dmm_mul_top_bench;
    typedef struct packed {
        dmm_pkg::dmm_res_t r;
        logic [3:0] f;
        logic we;
        logic [15:0] d;
        logic [31:0] st;
    } dmm_note_t;
    logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic res_valid_o, t3_we_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, ovf_flags_o, exp_flags;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [15:0] t3_data_o;
    dmm_pkg::dmm_op_t op_i;
    dmm_pkg::dmm_res_t res_o;
    dmm_pkg::dmm_mode_t mode_o, cur_mode;
    dmm_note_t notes[$];
    dmm_note_t nt;
    int mismatches, checks, ncnt, nops;

    dmm_mul_top dmm_mul_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_i(op_i),
        .res_valid_o(res_valid_o), .res_o(res_o), .t3_we_o(t3_we_o),
        .t3_data_o(t3_data_o), .ovf_flags_o(ovf_flags_o), .mode_o(mode_o));
    dmm_feed dmm_feed_inst (.clk_i(clk_i), .op_o(op_i));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ***************************************************************
    // Reference arithmetic and checking tasks
    // ***************************************************************
    function automatic logic [16:0] ext17(logic [15:0] v, logic sx);
        return {sx & v[15], v};
    endfunction

    function automatic dmm_pkg::dmm_res_t ref_mul(dmm_pkg::dmm_op_t o);
        logic [16:0] a, b, sa, k, mx, my;
        logic signed [33:0] p;
        logic [31:0] r;
        logic [40:0] s;
        dmm_pkg::dmm_res_t q;
        sa = o.source_accumulator[32:16];
        k = {{9{o.short_immediate_constant[7]}}, o.short_immediate_constant};
        mx = ext17(o.mem_x, !o.uns_x && cur_mode.sign_extension_mode_bit);
        my = ext17(o.mem_y, !o.uns_y && cur_mode.sign_extension_mode_bit);
        case (o.form)
            dmm_pkg::FORM_ACC_ACC: {a, b} = {sa, o.dest_accumulator[32:16]};
            dmm_pkg::FORM_ACC_T: {a, b} = {sa, ext17(o.temp, 1'b1)};
            dmm_pkg::FORM_ACC_K8: {a, b} = {sa, k};
            dmm_pkg::FORM_MEM_ACC: {a, b} = {mx, sa};
            dmm_pkg::FORM_MEM_K8: {a, b} = {mx, k};
            default: {a, b} = {mx, my};
        endcase
        p = $signed(a) * $signed(b);
        if (cur_mode.fractional_mode_bit) p = p <<< 1;
        r = p[31:0];
        if (cur_mode.saturate_on_multiply_bit && cur_mode.fractional_mode_bit
            && a == dmm_pkg::OPND_MIN && b == dmm_pkg::OPND_MIN) begin
            r = dmm_pkg::MUL_SAT;
        end
        s = {{9{r[31]}}, r};
        if (o.rnd) begin
            if (!(cur_mode.rounding_method_bit && s[16:0] == 17'h08000)) begin
                s = s + dmm_pkg::RND_HALF;
            end
            s[15:0] = 16'h0000;
        end
        q.ovf = cur_mode.wide_overflow_mode_bit ? s[40] != s[39] :
            !(s[40:31] == 10'h000 || s[40:31] == 10'h3ff);
        q.acc = s[39:0];
        if (q.ovf && cur_mode.data_saturation_bit) begin
            if (cur_mode.wide_overflow_mode_bit) begin
                q.acc = s[40] ? dmm_pkg::SAT40_NEG : dmm_pkg::SAT40_POS;
            end else begin
                q.acc = s[40] ? dmm_pkg::SAT32_NEG : dmm_pkg::SAT32_POS;
            end
        end
        q.dst_idx = o.dst_idx;
        return q;
    endfunction

    task automatic fail(input string what);
        mismatches++;
        $display("unexpected at %0t: %0s", $time, what);
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        checks++;
        if (got !== exp) fail($sformatf("%0s %h not %h", what, got, exp));
    endtask

    task automatic chk_res(input dmm_pkg::dmm_res_t got,
                           input dmm_pkg::dmm_res_t exp);
        checks++;
        if (got !== exp) fail($sformatf("result %h not %h", got, exp));
    endtask

    // Classic single cycle; the request stands until ack is sampled high.
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) fail("no bus ack");
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic run_op(input int f);
        logic [159:0] rv;
        dmm_pkg::dmm_op_t o;
        dmm_note_t n;
        rv = {$urandom, $urandom, $urandom, $urandom, $urandom};
        o = rv[148:0];
        o.valid = 1'b1;
        o.form = dmm_pkg::dmm_form_t'(6'h01 << f);
        // Extreme operands make saturation and rounding overflow likely.
        if (rv[159:158] == 2'b00) begin
            o.source_accumulator[32:16] = dmm_pkg::OPND_MIN;
            o.dest_accumulator[32:16] = dmm_pkg::OPND_MIN;
            {o.temp, o.mem_x, o.mem_y} = {3{16'h8000}};
        end
        n.r = ref_mul(o);
        if (n.r.ovf) exp_flags[o.dst_idx] = 1'b1;
        n.f = exp_flags;
        n.we = o.copy_t3 && (|o.form[5:3]);
        n.d = o.mem_x;
        dmm_feed_inst.send(o);
        n.st = 32'(ncnt + 2);
        notes.push_back(n);
        nops++;
        dmm_feed_inst.rest(int'(rv[157:156]) % 3);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ***************************************************************
    // Result monitor, main sequence and watchdog
    // ***************************************************************
    always @(negedge clk_i) begin
        ncnt++;
        if (res_valid_o === 1'b1) begin
            if (notes.size() == 0) begin
                fail("result without request");
            end else begin
                nt = notes.pop_front();
                chk32(32'(ncnt), nt.st, "latency");
                chk_res(res_o, nt.r);
                chk32(32'(res_o.acc[39:32]), 32'(nt.r.acc[39:32]),
                    "top");
                chk32(32'(res_o.ovf), 32'(nt.r.ovf), "ovf");
                chk32(32'(ovf_flags_o), 32'(nt.f), "flags");
                chk32({15'h0, t3_we_o, nt.we ? t3_data_o : 16'h0},
                    {15'h0, nt.we, nt.d & {16{nt.we}}}, "t3");
            end
        end else if (notes.size() > 0 && notes[0].st < 32'(ncnt)) begin
            fail("result missing");
            void'(notes.pop_front());
        end
    end

    initial begin
        {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b11000;
        {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {mismatches, checks, ncnt, nops} = '0;
        exp_flags = 4'h0;
        rd = $urandom(32'h1fe5);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        cur_mode = dmm_pkg::MODE_RST;
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, 8'(4 * i), 32'h0, 4'hf, rd);
            chk32(rd, i == 0 ? 32'(dmm_pkg::MODE_RST) : 32'h0, "reset read");
        end
        $display("test reset done");
        for (int m = 0; m < 128; m++) begin
            wb(1'b1, dmm_pkg::OFS_MODE, {25'($urandom), 7'(m)}, 4'h1, rd);
            cur_mode = dmm_pkg::dmm_mode_t'(7'(m));
            chk32(32'(mode_o), 32'(cur_mode), "mode");
            for (int f = 0; f < 6; f++) run_op(f);
            dmm_feed_inst.rest(2);
        end
        wb(1'b1, dmm_pkg::OFS_MODE, 32'h0, 4'he, rd);
        chk32(32'(mode_o), 32'(cur_mode), "mode sel");
        $display("test multiply modes done");
        wb(1'b0, dmm_pkg::OFS_STATUS, 32'h0, 4'hf, rd);
        chk32(rd, 32'(exp_flags), "status");
        wb(1'b1, dmm_pkg::OFS_STATUS, 32'hf, 4'he, rd);
        wb(1'b1, dmm_pkg::OFS_STATUS, 32'h5, 4'h1, rd);
        exp_flags = exp_flags & 4'ha;
        wb(1'b0, dmm_pkg::OFS_STATUS, 32'h0, 4'hf, rd);
        chk32(rd, 32'(exp_flags), "status clear");
        chk32(32'(ovf_flags_o), 32'(exp_flags), "flag pins");
        // A valid op offered while the clock enable is low must be ignored,
        // so the count read below also proves the freeze.
        ce_i <= 1'b0;
        dmm_feed_inst.send(dmm_pkg::dmm_op_t'({1'b1, 6'h01, 142'h0}));
        dmm_feed_inst.rest(1);
        ce_i <= 1'b1;
        wb(1'b1, dmm_pkg::OFS_COUNT, 32'h0, 4'hf, rd);
        wb(1'b0, dmm_pkg::OFS_COUNT, 32'h0, 4'hf, rd);
        chk32(rd, 32'(nops), "count");
        wb(1'b1, 8'h40, 32'hffff_ffff, 4'hf, rd);
        wb(1'b0, 8'h40, 32'h0, 4'hf, rd);
        chk32(rd, 32'h0, "unmapped");
        chk32(32'(mode_o), 32'(cur_mode), "mode kept");
        $display("test registers done");
        print_verdict();
    end

    initial begin
        repeat (30000) @(posedge clk_i);
        fail("watchdog");
        print_verdict();
    end
endmodule
